/* File: design/mesu_sync.v */
// Three-stage synchroniser bank with agreement filter for external levels.
`default_nettype none

module mesu_sync #(
    parameter WIDTH = 8
) (
    input wire clock,
    input wire rst_n,
    input wire [WIDTH-1:0] async_in,
    input wire [WIDTH-1:0] reset_val,
    output reg [WIDTH-1:0] level_q
);

    reg [WIDTH-1:0] s1_q;
    reg [WIDTH-1:0] s2_q;
    reg [WIDTH-1:0] s3_q;

    genvar g;
    generate
        for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
            // The first stage feeds only the second to keep metastability out.
            always @(posedge clock) begin
                if (!rst_n) begin
                    s1_q[g] <= reset_val[g];
                    s2_q[g] <= reset_val[g];
                    s3_q[g] <= reset_val[g];
                    level_q[g] <= reset_val[g];
                end else begin
                    s1_q[g] <= async_in[g];
                    s2_q[g] <= s1_q[g];
                    s3_q[g] <= s2_q[g];
                    if (s2_q[g] == s3_q[g]) begin
                        level_q[g] <= s3_q[g];
                    end
                end
            end
        end
    endgenerate

endmodule // mesu_sync

`default_nettype wire

/* File: design/mesu_unit.v */
// Event flags, interrupt enables, system status and control of the meter.
//
// Added by the designer: the address-and-strobe port.
`default_nettype none
`include "mesu_defines.vh"

module mesu_unit (
    input wire clock,
    input wire rst_n,
    input wire [9:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_write,
    input wire reg_read,
    output reg [31:0] reg_rdata_q,
    input wire voltage_zero_cross_flag,
    input wire wave_overrun_event,
    input wire wave_capture_done_event,
    input wire waveform_refresh_flag,
    input wire instant_rms_refresh_flag,
    input wire mean_rms_refresh_flag,
    input wire instant_power_refresh_flag,
    input wire mean_power_refresh_flag,
    input wire phase_meas_start,
    input wire phase_meas_finish,
    input wire wave_capture_step,
    input wire wave_capture_clear,
    input wire checksum_bad,
    input wire [7:0] grid_conditions,
    input wire [7:0] creep_flags,
    input wire [3:0] power_negative,
    input wire ram_selftest_bad,
    input wire ram_init_complete,
    input wire supply_low_pin,
    input wire reference_droop_pin,
    input wire ext_clock_abnormal_pin,
    input wire [2:0] reset_cause_in,
    input wire reset_cause_valid,
    output reg irq_pin_q,
    output reg irq_active_q
);

    // ------------------------------------------------------------------------
    // Pin inputs from other domains.
    // ------------------------------------------------------------------------
    wire [2:0] pins_s;

    mesu_sync #(
        .WIDTH(3)
    ) u_sync (
        .clock(clock),
        .rst_n(rst_n),
        .async_in({ext_clock_abnormal_pin, reference_droop_pin,
                   supply_low_pin}),
        .reset_val(3'h0),
        .level_q(pins_s)
    );

    wire supply_low_s = pins_s[0];
    wire reference_droop_s = pins_s[1];
    wire ext_clock_abnormal_s = pins_s[2];

    // ------------------------------------------------------------------------
    // Registers.
    // ------------------------------------------------------------------------
    reg [31:0] flag_q;
    reg [31:0] flag_d;
    reg [31:0] enable_q;
    reg [5:0] misc_ctl_q;
    reg [8:0] waveform_capture_count_q;
    reg [2:0] reset_cause_q;
    reg [3:0] sign_q;
    reg phase_meas_complete_q;
    reg checksum_bad_q;
    reg supply_low_prev_q;
    reg first_cycle_q;

    wire wr_flag = reg_write && (reg_addr == `MESU_ADDR_FLAG);
    wire wr_enable = reg_write && (reg_addr == `MESU_ADDR_ENABLE);
    wire wr_misc = reg_write && (reg_addr == `MESU_ADDR_MISC);

    // Checksum edge detect; the first cycle after reset is not an edge
    // because the status bit already resets to the incorrect state.
    wire cfg_fault_edge = checksum_bad && !checksum_bad_q;
    wire supply_drop_edge = supply_low_s && !supply_low_prev_q;

    reg [31:0] set_vec;
    always @* begin
        set_vec = 32'h0;
        set_vec[`MESU_FLAG_VZC] = voltage_zero_cross_flag;
        set_vec[`MESU_FLAG_WOVF] = wave_overrun_event;
        set_vec[`MESU_FLAG_WDONE] = wave_capture_done_event;
        set_vec[6] = waveform_refresh_flag;
        set_vec[5] = instant_rms_refresh_flag;
        set_vec[4] = mean_rms_refresh_flag;
        set_vec[3] = instant_power_refresh_flag;
        set_vec[`MESU_FLAG_REFR_LO] = mean_power_refresh_flag;
        set_vec[`MESU_FLAG_SDROP] = supply_drop_edge;
        set_vec[`MESU_FLAG_PHS] = phase_meas_finish;
        set_vec[`MESU_FLAG_CFG] = cfg_fault_edge;
    end

    // Sets win over a same-cycle write-one clear so no event is lost.
    always @* begin
        flag_d = flag_q;
        if (wr_flag) begin
            flag_d = flag_d & ~reg_wdata;
        end
        if (phase_meas_start) begin
            flag_d[`MESU_FLAG_PHS] = 1'b0;
        end
        flag_d = (flag_d | set_vec) & `MESU_FLAG_IMPL_MASK;
    end

    always @(posedge clock) begin
        if (!rst_n) begin
            flag_q <= 32'h0;
            enable_q <= 32'h0;
            misc_ctl_q <= 6'h0;
            checksum_bad_q <= 1'b1;
            supply_low_prev_q <= 1'b0;
        end else begin
            flag_q <= flag_d;
            checksum_bad_q <= checksum_bad;
            supply_low_prev_q <= supply_low_s;
            if (wr_enable) begin
                enable_q <= reg_wdata & `MESU_ENABLE_MASK;
            end
            if (wr_misc) begin
                misc_ctl_q <= reg_wdata[5:0];
            end
        end
    end

    // ------------------------------------------------------------------------
    // Status state.
    // ------------------------------------------------------------------------
    always @(posedge clock) begin
        if (!rst_n) begin
            sign_q <= 4'h0;
            phase_meas_complete_q <= 1'b0;
            waveform_capture_count_q <= 9'h0;
            first_cycle_q <= 1'b1;
        end else begin
            first_cycle_q <= 1'b0;
            // Sign b: reactive bit 3 follows creep bit 4, active bit 2 bit 3;
            // channel a: reactive bit 1 creep bit 1, active bit 0 creep bit 0.
            if (!creep_flags[4]) begin
                sign_q[3] <= power_negative[3];
            end
            if (!creep_flags[3]) begin
                sign_q[2] <= power_negative[2];
            end
            if (!creep_flags[1]) begin
                sign_q[1] <= power_negative[1];
            end
            if (!creep_flags[0]) begin
                sign_q[0] <= power_negative[0];
            end
            if (phase_meas_start) begin
                phase_meas_complete_q <= 1'b0;
            end else if (phase_meas_finish) begin
                phase_meas_complete_q <= 1'b1;
            end
            if (wave_capture_clear) begin
                waveform_capture_count_q <= 9'h0;
            end else if (wave_capture_step) begin
                waveform_capture_count_q <= waveform_capture_count_q
                                            + 9'h001;
            end
        end
    end

    // The cause strap is caught on the clock after release, never by reset.
    always @(posedge clock) begin
        if (!rst_n) begin
            reset_cause_q <= `MESU_RST_NONE;
        end else if (first_cycle_q || reset_cause_valid) begin
            reset_cause_q <= reset_cause_in;
        end
    end

    wire [31:0] state_word = {
        1'b0,
        grid_conditions,
        reset_cause_q,
        creep_flags,
        sign_q,
        1'b0,
        ext_clock_abnormal_s,
        ram_selftest_bad,
        ram_init_complete,
        phase_meas_complete_q,
        supply_low_s,
        reference_droop_s,
        checksum_bad_q
    };

    wire [31:0] misc_word = {7'h00, waveform_capture_count_q, 10'h000,
                             misc_ctl_q};

    // ------------------------------------------------------------------------
    // Read port and interrupt output.
    // ------------------------------------------------------------------------
    reg [31:0] rd_d;
    always @* begin
        case (reg_addr)
            `MESU_ADDR_FLAG: rd_d = flag_q;
            `MESU_ADDR_ENABLE: rd_d = enable_q;
            `MESU_ADDR_STATE: rd_d = state_word;
            `MESU_ADDR_MISC: rd_d = misc_word;
            default: rd_d = 32'h0;
        endcase
    end

    wire irq_any = |(flag_q & enable_q);

    always @(posedge clock) begin
        if (!rst_n) begin
            reg_rdata_q <= 32'h0;
            irq_active_q <= 1'b0;
            irq_pin_q <= 1'b0;
        end else begin
            reg_rdata_q <= reg_read ? rd_d : 32'h0;
            irq_active_q <= irq_any;
            irq_pin_q <= irq_any ^ misc_ctl_q[`MESU_MISC_POL];
        end
    end

endmodule // mesu_unit

`default_nettype wire

/* File: pkg/mesu_defines.vh */
// Register map, field positions and reset cause codes of the metering event unit.
`ifndef MESU_DEFINES_VH
`define MESU_DEFINES_VH

// ----------------------------------------------------------------------------
// Register indices; byte address is four times the index.
// ----------------------------------------------------------------------------
`define MESU_IDX_FLAG 8'h72
`define MESU_IDX_ENABLE 8'h73
`define MESU_IDX_STATE 8'h74
`define MESU_IDX_MISC 8'h75
`define MESU_ADDR_FLAG 10'h1C8
`define MESU_ADDR_ENABLE 10'h1CC
`define MESU_ADDR_STATE 10'h1D0
`define MESU_ADDR_MISC 10'h1D4

// ----------------------------------------------------------------------------
// Field positions.
// ----------------------------------------------------------------------------
`define MESU_FLAG_VZC 9
`define MESU_FLAG_WOVF 8
`define MESU_FLAG_WDONE 7
`define MESU_FLAG_REFR_HI 6
`define MESU_FLAG_REFR_LO 2
`define MESU_FLAG_SDROP 1
`define MESU_FLAG_PHS 0
`define MESU_FLAG_CFG 14
`define MESU_ENABLE_MASK 32'h3FF9FFFF
`define MESU_FLAG_IMPL_MASK 32'h000043FF
`define MESU_MISC_POL 2
`define MESU_MISC_RW_MASK 32'h0000003F
`define MESU_RST_POR 3'h1
`define MESU_RST_PIN 3'h2
`define MESU_RST_RXLOW 3'h3
`define MESU_RST_SOFT 3'h4
`define MESU_RST_NONE 3'h0

`endif

/* File: tb/mesu_unit_props.sv */
// Concurrent checks on the ports of the metering event unit.
`default_nettype none
`include "mesu_defines.vh"
module mesu_unit_props (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [9:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [31:0] reg_rdata_q,
    input wire logic voltage_zero_cross_flag,
    input wire logic phase_meas_finish,
    input wire logic [7:0] grid_conditions,
    input wire logic [7:0] creep_flags,
    input wire logic irq_pin_q,
    input wire logic irq_active_q
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] en_q;
    logic pol_q;
    // Shadow copies let the interrupt outputs be predicted from writes.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            en_q <= 32'h0;
            pol_q <= 1'b0;
        end else if (reg_write && reg_addr == `MESU_ADDR_ENABLE) begin
            en_q <= reg_wdata & `MESU_ENABLE_MASK;
        end else if (reg_write && reg_addr == `MESU_ADDR_MISC) begin
            pol_q <= reg_wdata[2];
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    sequence rd_s(logic [9:0] a);
        reg_read && reg_addr == a;
    endsequence
    sequence vzc_s;
        voltage_zero_cross_flag && en_q[9] && !reg_write;
    endsequence
    AST_VZC_IRQ: assert property (vzc_s |-> ##2 irq_active_q)
        else $error("zero crossing did not raise irq");
    AST_PHS_IRQ: assert property
        (phase_meas_finish && en_q[0] && !reg_write |-> ##2 irq_active_q)
        else $error("phase done did not raise irq");
    AST_NO_EN: assert property (en_q == 32'h0 |=> !irq_active_q)
        else $error("irq active with all enables off");
    AST_PIN_POL: assert property
        ($past(rst_n) |-> irq_pin_q == (irq_active_q ^ $past(pol_q)))
        else $error("irq pin polarity wrong");
    AST_EN_READ: assert property
        (rd_s(`MESU_ADDR_ENABLE) |=> reg_rdata_q == $past(en_q))
        else $error("enable readback wrong");
    AST_FLAG_RSV: assert property (rd_s(`MESU_ADDR_FLAG) |=>
        (reg_rdata_q & ~`MESU_FLAG_IMPL_MASK) == 32'h0)
        else $error("flag reserved bits set");
    AST_GRID: assert property (rd_s(`MESU_ADDR_STATE) |=>
        reg_rdata_q[30:23] == $past(grid_conditions)
        && reg_rdata_q[19:12] == $past(creep_flags))
        else $error("grid or creep status wrong");
    AST_MISC_RO: assert property (rd_s(`MESU_ADDR_MISC) |=>
        reg_rdata_q[31:25] == 7'h0 && reg_rdata_q[15:6] == 10'h0)
        else $error("misc reserved bits set");
    AST_RD_IDLE: assert property (!reg_read |=> reg_rdata_q == 32'h0)
        else $error("read data outside read slot");
endmodule // mesu_unit_props
bind mesu_unit mesu_unit_props mesu_unit_props_i (.clock(clock),
    .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata_q(reg_rdata_q),
    .voltage_zero_cross_flag(voltage_zero_cross_flag),
    .phase_meas_finish(phase_meas_finish),
    .grid_conditions(grid_conditions), .creep_flags(creep_flags),
    .irq_pin_q(irq_pin_q), .irq_active_q(irq_active_q));
`default_nettype wire

/* File: tb/tb.sv */
// Self-checking testbench of the metering event unit.
`default_nettype none
`include "mesu_defines.vh"
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock, rst_n, we, re, cb, rsb, rin, slp, rdp, ecp, rcv, irqp, irqa;
    logic [9:0] ad;
    logic [31:0] wd, rdq, en;
    logic [11:0] pv;
    logic [7:0] gr, cr;
    logic [3:0] ng, nk;
    logic [2:0] rci;
    int err_total, checks_done, seed, i;
    mesu_unit mesu_unit_i (.clock(clock), .rst_n(rst_n), .reg_addr(ad),
        .reg_wdata(wd), .reg_write(we), .reg_read(re), .reg_rdata_q(rdq),
        .voltage_zero_cross_flag(pv[7]), .wave_overrun_event(pv[6]),
        .wave_capture_done_event(pv[5]), .waveform_refresh_flag(pv[4]),
        .instant_rms_refresh_flag(pv[3]), .mean_rms_refresh_flag(pv[2]),
        .instant_power_refresh_flag(pv[1]), .mean_power_refresh_flag(pv[0]),
        .phase_meas_start(pv[8]), .phase_meas_finish(pv[9]),
        .wave_capture_step(pv[10]), .wave_capture_clear(pv[11]),
        .checksum_bad(cb), .grid_conditions(gr), .creep_flags(cr),
        .power_negative(ng), .ram_selftest_bad(rsb), .ram_init_complete(rin),
        .supply_low_pin(slp), .reference_droop_pin(rdp),
        .ext_clock_abnormal_pin(ecp), .reset_cause_in(rci),
        .reset_cause_valid(rcv), .irq_pin_q(irqp), .irq_active_q(irqa));
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    task automatic summarize;
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e) begin
            err_total++;
            $display("mismatch at %0t: got %h want %h", $time, g, e);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic wr(input logic [9:0] a, input logic [31:0] d);
        @(posedge clock);
        ad <= a;
        wd <= d;
        we <= 1'b1;
        @(posedge clock);
        we <= 1'b0;
    endtask
    // Read data stands for one cycle only, so it is sampled right then.
    task automatic rd(input logic [9:0] a, input logic [31:0] m,
                      input logic [31:0] e);
        @(posedge clock);
        ad <= a;
        re <= 1'b1;
        @(posedge clock);
        re <= 1'b0;
        #1 chk(rdq & m, e);
    endtask
    task automatic pulse(input int k);
        @(posedge clock);
        pv <= 12'h1 << k;
        @(posedge clock);
        pv <= 12'h0;
    endtask
    initial begin
        repeat (20000) @(posedge clock);
        err_total++;
        summarize;
    end
    initial begin
        seed = 41;
        {rst_n, we, re, slp, rdp, ecp, rsb, rin, rcv, ad, wd, pv} = '0;
        {gr, cr, ng, rci} = '0;
        cb = 1'b1;
        tick(5);
        rst_n <= 1'b1;
        rd(`MESU_ADDR_ENABLE, '1, 32'h0);
        rd(`MESU_ADDR_STATE, 32'h1, 32'h1);
        cb <= 1'b0;
        tick(3);
        rd(`MESU_ADDR_STATE, 32'h1, 32'h0);
        cb <= 1'b1;
        tick(3);
        rd(`MESU_ADDR_FLAG, '1, 32'h4000);
        wr(`MESU_ADDR_FLAG, 32'h4000);
        rd(`MESU_ADDR_FLAG, '1, 32'h0);
        $display("reset and checksum test done");
        // Reserved enable bits stay at their defaults; bits 9 and 0 are
        // forced on so the zero-crossing and phase interrupts can be seen.
        en = ($random(seed) & 32'h3FF9FFFF) | 32'h00000201;
        wr(`MESU_ADDR_ENABLE, en);
        en = en & 32'h3FF9FFFF;
        rd(`MESU_ADDR_ENABLE, '1, en);
        for (i = 0; i < 8; i++) begin
            pulse(i);
            tick(2);
            chk(irqa, en[i+2]);
            wr(`MESU_ADDR_FLAG, 32'h0);
            rd(`MESU_ADDR_FLAG, '1, 32'h4 << i);
            wr(`MESU_ADDR_FLAG, 32'h4 << i);
            rd(`MESU_ADDR_FLAG, '1, 32'h0);
        end
        pulse(9);
        tick(2);
        chk(irqa, 1'b1);
        rd(`MESU_ADDR_STATE, 32'h8, 32'h8);
        pulse(8);
        rd(`MESU_ADDR_FLAG, 32'h1, 32'h0);
        rd(`MESU_ADDR_STATE, 32'h8, 32'h0);
        wr(`MESU_ADDR_MISC, 32'h4);
        tick(2);
        chk({irqa, irqp}, 2'b01);
        $display("flag and irq test done");
        {slp, rdp, ecp, rsb, rin} <= 5'h1F;
        tick(8);
        rd(`MESU_ADDR_STATE, 32'h76, 32'h76);
        {slp, rdp, ecp} <= 3'h0;
        tick(8);
        rd(`MESU_ADDR_STATE, 32'h46, 32'h0);
        rd(`MESU_ADDR_FLAG, '1, 32'h2);
        gr <= $random(seed);
        nk = $random(seed);
        ng <= nk;
        tick(3);
        rd(`MESU_ADDR_STATE, 32'h7F8FFF00,
           {1'b0, gr, 3'h0, cr, nk, 8'h0});
        cr <= 8'h1B;
        ng <= ~nk;
        tick(3);
        rd(`MESU_ADDR_STATE, 32'h000FFF00, {12'h0, cr, nk, 8'h0});
        for (i = 0; i < 3; i++) pulse(10);
        rd(`MESU_ADDR_MISC, 32'h01FF0000, 32'h00030000);
        pulse(11);
        rd(`MESU_ADDR_MISC, '1, 32'h4);
        for (i = 1; i < 5; i++) begin
            @(posedge clock);
            rci <= i[2:0];
            rcv <= 1'b1;
            @(posedge clock);
            rcv <= 1'b0;
            rd(`MESU_ADDR_STATE, 32'h700000, i << 20);
        end
        rd(10'h1D8, '1, 32'h0);
        $display("status and control test done");
        summarize;
    end
endmodule // tb
`default_nettype wire
